// File: rtl/arrays_if.sv
// carrier between the operation logic and the lookup arrays
interface arrays_if;
  logic [6:0] tlb_index;
  logic [1:0] tlb_set;
  logic tlb_we;
  logic [63:0] tlb_wr_hi;
  logic [63:0] tlb_wr_lo;
  logic [63:0] tlb_rd_hi;
  logic [63:0] tlb_rd_lo;
  logic [63:0] probe_key;
  logic [35:0] vpn_mask;
  logic probe_hit;
  logic [1:0] probe_set;
  logic [5:0] dtag_index;
  logic dtag_we;
  logic [63:0] dtag_wdata;
  logic [63:0] dtag_rdata;
  modport owner (output tlb_index, tlb_set, tlb_we, tlb_wr_hi, tlb_wr_lo, probe_key,
    vpn_mask, dtag_index, dtag_we, dtag_wdata,
    input tlb_rd_hi, tlb_rd_lo, probe_hit, probe_set, dtag_rdata);
  modport store (input tlb_index, tlb_set, tlb_we, tlb_wr_hi, tlb_wr_lo, probe_key,
    vpn_mask, dtag_index, dtag_we, dtag_wdata,
    output tlb_rd_hi, tlb_rd_lo, probe_hit, probe_set, dtag_rdata);
endinterface

// File: rtl/cop_ops_pkg.sv
// constants, field positions and operation kinds for the system control operations
package cop_ops_pkg;
  // ----------------------------------------------------------------
  // instruction encoding
  // ----------------------------------------------------------------
  localparam logic [5:0] major_cop = 6'h10;
  localparam logic [4:0] rs_move_from = 5'h01;
  localparam logic [4:0] rs_move_to = 5'h05;
  localparam logic [4:0] rs_coi = 5'h10;
  localparam logic [4:0] rs_com = 5'h18;
  localparam logic [5:0] fn_exc_ret = 6'h18;
  localparam logic [5:0] fn_tlb_read = 6'h01;
  localparam logic [5:0] fn_tlb_write = 6'h02;
  localparam logic [5:0] fn_tlb_probe = 6'h08;
  localparam logic [5:0] fn_tag_read = 6'h09;
  localparam logic [5:0] fn_tag_write = 6'h0a;
  localparam logic [31:0] barrier_word = 32'h0000_0040;
  localparam logic [4:0] gpr_zero = 5'h00;
  // ----------------------------------------------------------------
  // coprocessor register numbers
  // ----------------------------------------------------------------
  localparam logic [4:0] creg_set_select = 5'h00;
  localparam logic [4:0] creg_entry_low = 5'h02;
  localparam logic [4:0] creg_probe_addr = 5'h08;
  localparam logic [4:0] creg_entry_high = 5'h0a;
  localparam logic [4:0] creg_status = 5'h0c;
  localparam logic [4:0] creg_return_pc = 5'h0e;
  localparam logic [4:0] creg_cache_tag = 5'h1c;
  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam int status_clear_bit = 1;
  localparam int user_size_lsb = 8;
  localparam int kern_size_lsb = 10;
  localparam int miss_bit = 31;
  localparam int region_lsb = 62;
  localparam int vpn_lsb = 12;
  localparam int vpn_w = 36;
  localparam int tag_w = 8;
  localparam int tlb_idx_w = 7;
  localparam int dtag_idx_w = 6;
  localparam int dtag_lsb = 7;
  localparam logic [5:0] page_base = 6'h0c;
  localparam logic [1:0] region_user = 2'h0;
  localparam logic [1:0] region_kphys = 2'h2;
  localparam logic [63:0] reg_reset = 64'h0000_0000_0000_0000;
  // ----------------------------------------------------------------
  // register bus map, 8 bytes per register
  // ----------------------------------------------------------------
  localparam logic [2:0] sel_probe_addr = 3'h0;
  localparam logic [2:0] sel_entry_high = 3'h1;
  localparam logic [2:0] sel_entry_low = 3'h2;
  localparam logic [2:0] sel_set_select = 3'h3;
  localparam logic [2:0] sel_status = 3'h4;
  localparam logic [2:0] sel_return_pc = 3'h5;
  localparam logic [2:0] sel_cache_tag = 3'h6;
  localparam logic [2:0] sel_link = 3'h7;
  localparam logic [1:0] page_mapped = 2'h0;
  typedef enum logic [3:0] {
    op_none = 4'b0000,
    op_move_from = 4'b0001,
    op_move_to = 4'b0010,
    op_exc_ret = 4'b0011,
    op_tlb_read = 4'b0100,
    op_tlb_write = 4'b0101,
    op_tlb_probe = 4'b0110,
    op_tag_read = 4'b0111,
    op_tag_write = 4'b1000,
    op_barrier = 4'b1001
  } op_kind_t;
endpackage

// File: rtl/cop_ops_top.sv
// system control operation execution with register bus access
//
// Contract
// - tag read loads holding register from array
// - tag write stores holding register to array
// - move from copies coprocessor reg rt
// - move to copies general reg rt
// - exception return loads pc, clears status bit
// - exception return clears link flag
// - special shift encoding decodes as barrier
// - hold followers until barrier dispatched
// - barrier changes no register, raises only op_done
// - probe compares region, page, space tag
// - probe hit clears miss, records set
// - tlb read loads entry high, low
// - unusable coprocessor raises exception instead
// - general register zero never written
// - link flag set, cleared, read
// - index from page size, kernel physical fixed
module cop_ops_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic op_valid,
  input wire logic [31:0] op_word,
  input wire logic [63:0] op_rt_data,
  input wire logic cop_usable,
  input wire logic ll_event,
  input wire logic invalidate_event,
  output logic op_ready,
  output logic op_done,
  output logic gpr_we,
  output logic [4:0] gpr_waddr,
  output logic [63:0] gpr_wdata,
  output logic pc_load,
  output logic [63:0] pc_value,
  output logic squash_next,
  output logic cop_unusable_exc,
  output logic link_flag
);
  logic [63:0] probe_addr, entry_high, entry_low, set_select;
  logic [63:0] status, return_pc, cache_tag;
  logic [63:0] next_probe_addr, next_entry_high, next_entry_low, next_set_select;
  logic [63:0] next_status, next_return_pc, next_cache_tag;
  logic next_link_flag, next_op_ready, next_op_done, next_gpr_we;
  logic [4:0] next_gpr_waddr;
  logic [63:0] next_gpr_wdata, next_pc_value, cop_read;
  logic next_pc_load, next_squash_next, next_exc;
  logic [31:0] next_prdata, rd_word;
  logic next_pready, next_pslverr;
  cop_ops_pkg::op_kind_t kind;
  logic acc, is_cop, run, apb_wr, apb_setup, mapped;
  logic [1:0] ps;
  logic [5:0] shamt;
  logic [63:0] shifted;
  arrays_if arr();

  lookup_arrays u_arrays (
    .pclk(pclk),
    .ar(arr.store)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  always_comb
  begin
    kind = cop_ops_pkg::op_none;
    if (op_word == cop_ops_pkg::barrier_word)
    begin
      kind = cop_ops_pkg::op_barrier;
    end
    else if (op_word[31:26] == cop_ops_pkg::major_cop)
    begin
      case (op_word[25:21])
        cop_ops_pkg::rs_move_from: kind = cop_ops_pkg::op_move_from;
        cop_ops_pkg::rs_move_to: kind = cop_ops_pkg::op_move_to;
        cop_ops_pkg::rs_coi:
        begin
          if (op_word[5:0] == cop_ops_pkg::fn_exc_ret)
          begin
            kind = cop_ops_pkg::op_exc_ret;
          end
        end
        cop_ops_pkg::rs_com:
        begin
          case (op_word[5:0])
            cop_ops_pkg::fn_tlb_read: kind = cop_ops_pkg::op_tlb_read;
            cop_ops_pkg::fn_tlb_write: kind = cop_ops_pkg::op_tlb_write;
            cop_ops_pkg::fn_tlb_probe: kind = cop_ops_pkg::op_tlb_probe;
            cop_ops_pkg::fn_tag_read: kind = cop_ops_pkg::op_tag_read;
            cop_ops_pkg::fn_tag_write: kind = cop_ops_pkg::op_tag_write;
            default: kind = cop_ops_pkg::op_none;
          endcase
        end
        default: kind = cop_ops_pkg::op_none;
      endcase
    end
  end

  assign acc = op_valid && op_ready;
  assign is_cop = (kind != cop_ops_pkg::op_none) && (kind != cop_ops_pkg::op_barrier);
  assign run = acc && is_cop && cop_usable;

  // ----------------------------------------------------------------
  // translation index and array drive
  // ----------------------------------------------------------------
  always_comb
  begin
    ps = (probe_addr[63:cop_ops_pkg::region_lsb] == cop_ops_pkg::region_user)
      ? status[cop_ops_pkg::user_size_lsb +: 2] : status[cop_ops_pkg::kern_size_lsb +: 2];
    if (probe_addr[63:cop_ops_pkg::region_lsb] == cop_ops_pkg::region_kphys)
    begin
      ps = 2'h0;
    end
    shamt = cop_ops_pkg::page_base + {3'h0, ps, 1'b0};
    shifted = probe_addr >> shamt;
    arr.tlb_index = shifted[cop_ops_pkg::tlb_idx_w-1:0];
    arr.vpn_mask = {36{1'b1}} << {ps, 1'b0};
    arr.probe_key = {probe_addr[63:cop_ops_pkg::tag_w], entry_high[cop_ops_pkg::tag_w-1:0]};
    arr.tlb_set = set_select[1:0];
    arr.tlb_we = run && (kind == cop_ops_pkg::op_tlb_write);
    arr.tlb_wr_hi = entry_high;
    arr.tlb_wr_lo = entry_low;
    arr.dtag_index = probe_addr[cop_ops_pkg::dtag_lsb +: cop_ops_pkg::dtag_idx_w];
    arr.dtag_we = run && (kind == cop_ops_pkg::op_tag_write);
    arr.dtag_wdata = cache_tag;
  end

  // ----------------------------------------------------------------
  // coprocessor register read select
  // ----------------------------------------------------------------
  always_comb
  begin
    case (op_word[20:16])
      cop_ops_pkg::creg_set_select: cop_read = set_select;
      cop_ops_pkg::creg_entry_low: cop_read = entry_low;
      cop_ops_pkg::creg_probe_addr: cop_read = probe_addr;
      cop_ops_pkg::creg_entry_high: cop_read = entry_high;
      cop_ops_pkg::creg_status: cop_read = status;
      cop_ops_pkg::creg_return_pc: cop_read = return_pc;
      cop_ops_pkg::creg_cache_tag: cop_read = cache_tag;
      default: cop_read = cop_ops_pkg::reg_reset;
    endcase
  end

  // ----------------------------------------------------------------
  // register bus read and decode
  // ----------------------------------------------------------------
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pready && pwrite && !pslverr;
  assign mapped = (paddr[7:6] == cop_ops_pkg::page_mapped) && (paddr[1:0] == 2'h0);

  function automatic logic [31:0] half(input logic [63:0] r, input logic h);
    half = h ? r[63:32] : r[31:0];
  endfunction

  function automatic logic [63:0] put(input logic [63:0] r, input logic h,
    input logic [31:0] d);
    put = h ? {d, r[31:0]} : {r[63:32], d};
  endfunction

  always_comb
  begin
    case (paddr[5:3])
      cop_ops_pkg::sel_probe_addr: rd_word = half(probe_addr, paddr[2]);
      cop_ops_pkg::sel_entry_high: rd_word = half(entry_high, paddr[2]);
      cop_ops_pkg::sel_entry_low: rd_word = half(entry_low, paddr[2]);
      cop_ops_pkg::sel_set_select: rd_word = half(set_select, paddr[2]);
      cop_ops_pkg::sel_status: rd_word = half(status, paddr[2]);
      cop_ops_pkg::sel_return_pc: rd_word = half(return_pc, paddr[2]);
      cop_ops_pkg::sel_cache_tag: rd_word = half(cache_tag, paddr[2]);
      cop_ops_pkg::sel_link: rd_word = paddr[2] ? 32'h0000_0000 : {31'h0, link_flag};
      default: rd_word = 32'h0000_0000;
    endcase
    next_pready = apb_setup;
    next_prdata = apb_setup ? (mapped ? rd_word : 32'h0000_0000) : prdata;
    next_pslverr = apb_setup && !mapped;
  end

  // ----------------------------------------------------------------
  // next state of registers and operation results
  // ----------------------------------------------------------------
  always_comb
  begin
    next_probe_addr = probe_addr;
    next_entry_high = entry_high;
    next_entry_low = entry_low;
    next_set_select = set_select;
    next_status = status;
    next_return_pc = return_pc;
    next_cache_tag = cache_tag;
    next_link_flag = link_flag;
    next_op_done = acc;
    next_gpr_we = 1'b0;
    next_gpr_waddr = gpr_waddr;
    next_gpr_wdata = gpr_wdata;
    next_pc_load = 1'b0;
    next_pc_value = pc_value;
    next_squash_next = 1'b0;
    next_exc = acc && is_cop && !cop_usable;
    next_op_ready = !(acc && (kind == cop_ops_pkg::op_barrier));
    if (apb_wr)
    begin
      case (paddr[5:3])
        cop_ops_pkg::sel_probe_addr: next_probe_addr = put(probe_addr, paddr[2], pwdata);
        cop_ops_pkg::sel_entry_high: next_entry_high = put(entry_high, paddr[2], pwdata);
        cop_ops_pkg::sel_entry_low: next_entry_low = put(entry_low, paddr[2], pwdata);
        cop_ops_pkg::sel_set_select: next_set_select = put(set_select, paddr[2], pwdata);
        cop_ops_pkg::sel_status: next_status = put(status, paddr[2], pwdata);
        cop_ops_pkg::sel_return_pc: next_return_pc = put(return_pc, paddr[2], pwdata);
        cop_ops_pkg::sel_cache_tag: next_cache_tag = put(cache_tag, paddr[2], pwdata);
        default: next_link_flag = link_flag;
      endcase
    end
    if (run)
    begin
      case (kind)
        cop_ops_pkg::op_move_from:
        begin
          next_gpr_we = (op_word[15:11] != cop_ops_pkg::gpr_zero);
          next_gpr_waddr = op_word[15:11];
          next_gpr_wdata = cop_read;
        end
        cop_ops_pkg::op_move_to:
        begin
          case (op_word[15:11])
            cop_ops_pkg::creg_set_select: next_set_select = op_rt_data;
            cop_ops_pkg::creg_entry_low: next_entry_low = op_rt_data;
            cop_ops_pkg::creg_probe_addr: next_probe_addr = op_rt_data;
            cop_ops_pkg::creg_entry_high: next_entry_high = op_rt_data;
            cop_ops_pkg::creg_status: next_status = op_rt_data;
            cop_ops_pkg::creg_return_pc: next_return_pc = op_rt_data;
            cop_ops_pkg::creg_cache_tag: next_cache_tag = op_rt_data;
            default: next_status = status;
          endcase
        end
        cop_ops_pkg::op_exc_ret:
        begin
          next_pc_load = 1'b1;
          next_pc_value = return_pc;
          next_squash_next = 1'b1;
          next_status[cop_ops_pkg::status_clear_bit] = 1'b0;
          next_link_flag = 1'b0;
        end
        cop_ops_pkg::op_tlb_read:
        begin
          next_entry_high = arr.tlb_rd_hi;
          next_entry_low = arr.tlb_rd_lo;
        end
        cop_ops_pkg::op_tlb_probe:
        begin
          next_set_select[cop_ops_pkg::miss_bit] = !arr.probe_hit;
          if (arr.probe_hit)
          begin
            next_set_select[1:0] = arr.probe_set;
          end
        end
        cop_ops_pkg::op_tag_read: next_cache_tag = arr.dtag_rdata;
        default: next_gpr_we = 1'b0;
      endcase
    end
    if (invalidate_event)
    begin
      next_link_flag = 1'b0;
    end
    if (ll_event)
    begin
      next_link_flag = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      probe_addr <= cop_ops_pkg::reg_reset;
      entry_high <= cop_ops_pkg::reg_reset;
      entry_low <= cop_ops_pkg::reg_reset;
      set_select <= cop_ops_pkg::reg_reset;
      status <= cop_ops_pkg::reg_reset;
      return_pc <= cop_ops_pkg::reg_reset;
      cache_tag <= cop_ops_pkg::reg_reset;
      link_flag <= 1'b0;
      op_ready <= 1'b0;
      op_done <= 1'b0;
      gpr_we <= 1'b0;
      gpr_waddr <= 5'h00;
      gpr_wdata <= cop_ops_pkg::reg_reset;
      pc_load <= 1'b0;
      pc_value <= cop_ops_pkg::reg_reset;
      squash_next <= 1'b0;
      cop_unusable_exc <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      probe_addr <= next_probe_addr;
      entry_high <= next_entry_high;
      entry_low <= next_entry_low;
      set_select <= next_set_select;
      status <= next_status;
      return_pc <= next_return_pc;
      cache_tag <= next_cache_tag;
      link_flag <= next_link_flag;
      op_ready <= next_op_ready;
      op_done <= next_op_done;
      gpr_we <= next_gpr_we;
      gpr_waddr <= next_gpr_waddr;
      gpr_wdata <= next_gpr_wdata;
      pc_load <= next_pc_load;
      pc_value <= next_pc_value;
      squash_next <= next_squash_next;
      cop_unusable_exc <= next_exc;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_tag_read;
    run && kind == cop_ops_pkg::op_tag_read |=> cache_tag == $past(arr.dtag_rdata);
  endproperty
  a_tag_read: assert property (p_tag_read) else $error("tag read lost");
  property p_tag_write;
    acc && kind == cop_ops_pkg::op_tag_write |-> arr.dtag_we == cop_usable;
  endproperty
  a_tag_write: assert property (p_tag_write) else $error("tag write gate");
  property p_move_from;
    run && kind == cop_ops_pkg::op_move_from && op_word[15:11] != cop_ops_pkg::gpr_zero
      |=> gpr_we && gpr_wdata == $past(cop_read) && gpr_waddr == $past(op_word[15:11]);
  endproperty
  a_move_from: assert property (p_move_from) else $error("move from wrong");
  property p_move_to;
    run && kind == cop_ops_pkg::op_move_to && op_word[15:11] == cop_ops_pkg::creg_status
      |=> status == $past(op_rt_data);
  endproperty
  a_move_to: assert property (p_move_to) else $error("move to wrong");
  property p_exc_ret;
    run && kind == cop_ops_pkg::op_exc_ret
      |=> pc_load && squash_next && pc_value == $past(return_pc)
      && !status[cop_ops_pkg::status_clear_bit] ##1 !pc_load;
  endproperty
  a_exc_ret: assert property (p_exc_ret) else $error("return wrong");
  property p_link;
    run && kind == cop_ops_pkg::op_exc_ret && !ll_event |=> !link_flag;
  endproperty
  a_link: assert property (p_link) else $error("link not cleared");
  property p_barrier;
    acc && kind == cop_ops_pkg::op_barrier |=> !op_ready && !cop_unusable_exc ##1 op_ready;
  endproperty
  a_barrier: assert property (p_barrier) else $error("barrier hold wrong");
  property p_probe;
    run && kind == cop_ops_pkg::op_tlb_probe && !apb_wr
      |=> set_select[cop_ops_pkg::miss_bit] == !$past(arr.probe_hit)
      && entry_high == $past(entry_high);
  endproperty
  a_probe: assert property (p_probe) else $error("probe result wrong");
  property p_unusable;
    acc && is_cop && !cop_usable |=> cop_unusable_exc && !gpr_we && !pc_load;
  endproperty
  a_unusable: assert property (p_unusable) else $error("no unusable trap");
  property p_gpr_zero;
    gpr_we |-> gpr_waddr != 5'h00;
  endproperty
  a_gpr_zero: assert property (p_gpr_zero) else $error("zero register written");
  property p_tlb_read;
    run && kind == cop_ops_pkg::op_tlb_read |=> entry_low == $past(arr.tlb_rd_lo);
  endproperty
  a_tlb_read: assert property (p_tlb_read) else $error("tlb read wrong");
  property p_apb;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_apb: assert property (p_apb) else $error("bus answer late");
  property p_cv_exc_ret;
    run && kind == cop_ops_pkg::op_exc_ret;
  endproperty
  c_exc_ret: cover property (p_cv_exc_ret);
  property p_cv_hit;
    run && kind == cop_ops_pkg::op_tlb_probe && arr.probe_hit;
  endproperty
  c_hit: cover property (p_cv_hit);
  property p_cv_barrier;
    acc && kind == cop_ops_pkg::op_barrier;
  endproperty
  c_barrier: cover property (p_cv_barrier);
  property p_cv_trap;
    acc && is_cop && !cop_usable;
  endproperty
  c_trap: cover property (p_cv_trap);
endmodule

// File: rtl/lookup_arrays.sv
// translation and data cache tag arrays with associative probe
module lookup_arrays (
  input wire logic pclk,
  arrays_if.store ar
);
  logic [63:0] tlb_hi [4][128];
  logic [63:0] tlb_lo [4][128];
  logic [63:0] dtag [64];
  // ----------------------------------------------------------------
  // writes
  // ----------------------------------------------------------------
  always_ff @(posedge pclk)
  begin
    if (ar.tlb_we)
    begin
      tlb_hi[ar.tlb_set][ar.tlb_index] <= ar.tlb_wr_hi;
      tlb_lo[ar.tlb_set][ar.tlb_index] <= ar.tlb_wr_lo;
    end
    if (ar.dtag_we)
    begin
      dtag[ar.dtag_index] <= ar.dtag_wdata;
    end
  end
  // ----------------------------------------------------------------
  // reads and probe compare, lowest set wins
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [63:0] hi;
    logic m;
    hi = '0;
    m = 1'b0;
    ar.tlb_rd_hi = tlb_hi[ar.tlb_set][ar.tlb_index];
    ar.tlb_rd_lo = tlb_lo[ar.tlb_set][ar.tlb_index];
    ar.dtag_rdata = dtag[ar.dtag_index];
    ar.probe_hit = 1'b0;
    ar.probe_set = 2'h0;
    for (int s = 3; s >= 0; s--)
    begin
      hi = tlb_hi[s][ar.tlb_index];
      m = (hi[63:cop_ops_pkg::region_lsb] == ar.probe_key[63:cop_ops_pkg::region_lsb])
        && (((hi[cop_ops_pkg::vpn_lsb +: cop_ops_pkg::vpn_w]
        ^ ar.probe_key[cop_ops_pkg::vpn_lsb +: cop_ops_pkg::vpn_w]) & ar.vpn_mask) == '0)
        && (hi[cop_ops_pkg::tag_w-1:0] == ar.probe_key[cop_ops_pkg::tag_w-1:0]);
      if (m)
      begin
        ar.probe_hit = 1'b1;
        ar.probe_set = 2'(s);
      end
    end
  end
endmodule

// File: tb/cop_pipe_model.sv
// pipeline side model that offers instructions to the operation logic
module cop_pipe_model (
  input wire logic pclk,
  input wire logic op_ready,
  output logic op_valid = 1'b0,
  output logic [31:0] op_word = 32'h0000_0000,
  output logic [63:0] op_rt_data = 64'h0000_0000_0000_0000
);
  timeunit 1ns;
  timeprecision 1ps;
  // offer one word, held until taken, then released with scrambled fields
  task automatic issue(input logic [31:0] w, input logic [63:0] d, output logic late);
    int n;
    @(posedge pclk);
    op_word <= w;
    op_rt_data <= d;
    op_valid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (op_ready !== 1'b1 && n < 50);
    late = (op_ready !== 1'b1);
    op_valid <= 1'b0;
    op_word <= ~w;
    op_rt_data <= ~d;
  endtask
endmodule

// File: tb/tb_system_control_cop_ops.sv
// self-checking bench for the system control operation logic
module tb_system_control_cop_ops;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic cop_usable = 1'b1;
  logic ll_event = 1'b0;
  logic invalidate_event = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, op_word;
  logic [63:0] op_rt_data, gpr_wdata, pc_value;
  logic [4:0] gpr_waddr;
  logic pready, pslverr, op_valid, op_ready, op_done, gpr_we, pc_load, squash_next;
  logic cop_unusable_exc, link_flag;
  int n_mismatch = 0;
  int n_compared = 0;
  always #20 pclk = ~pclk;
  cop_ops_top dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .op_valid, .op_word, .op_rt_data, .cop_usable, .ll_event,
    .invalidate_event, .op_ready, .op_done, .gpr_we, .gpr_waddr, .gpr_wdata,
    .pc_load, .pc_value, .squash_next, .cop_unusable_exc, .link_flag);
  cop_pipe_model pm (.pclk, .op_ready, .op_valid, .op_word, .op_rt_data);
  task automatic tally_and_finish();
    $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk({32'h0000_0000, r}, {32'h0000_0000, exp}, "read");
  endtask
  task automatic op(input logic [31:0] w);
    logic late;
    pm.issue(w, 64'ha5a5_0000_1234_5678, late);
    if (late)
    begin
      n_mismatch++;
      tally_and_finish();
    end
    @(negedge pclk);
  endtask
  function automatic logic [31:0] mv(input logic [4:0] s, input logic [4:0] t, input logic [4:0] d);
    return {cop_ops_pkg::major_cop, s, t, d, 11'h000};
  endfunction
  function automatic logic [31:0] com(input logic [4:0] s, input logic [5:0] fn);
    return {cop_ops_pkg::major_cop, s, 15'h0000, fn};
  endfunction
  task automatic ev(input logic l, input logic i);
    @(posedge pclk);
    ll_event <= l;
    invalidate_event <= i;
    @(posedge pclk);
    ll_event <= 1'b0;
    invalidate_event <= 1'b0;
    @(negedge pclk);
  endtask
  task automatic t_tag();
    op(mv(cop_ops_pkg::rs_move_to, 5'h05, cop_ops_pkg::creg_cache_tag));
    op(com(cop_ops_pkg::rs_com, cop_ops_pkg::fn_tag_write));
    wr(8'h30, 32'h0000_0000);
    op(com(cop_ops_pkg::rs_com, cop_ops_pkg::fn_tag_read));
    op(mv(cop_ops_pkg::rs_move_from, cop_ops_pkg::creg_cache_tag, 5'h03));
    chk(gpr_we, 1, "we");
    chk(gpr_waddr, 3, "waddr");
    chk(gpr_wdata, 64'ha5a5_0000_1234_5678, "wdata");
    op(mv(cop_ops_pkg::rs_move_from, cop_ops_pkg::creg_cache_tag, 5'h00));
    chk(gpr_we, 0, "we zero");
    $display("t_tag done");
  endtask
  task automatic t_exc_ret();
    wr(8'h20, 32'h0000_0002);
    wr(8'h28, 32'h0000_4000);
    wr(8'h2c, 32'h0000_0001);
    ev(1'b1, 1'b0);
    chk(link_flag, 1, "link set");
    ev(1'b0, 1'b1);
    chk(link_flag, 0, "link inval");
    ev(1'b1, 1'b1);
    chk(link_flag, 1, "link set wins");
    op(com(cop_ops_pkg::rs_coi, cop_ops_pkg::fn_exc_ret));
    chk({pc_load, squash_next}, 3, "pc load");
    chk(pc_value, 64'h0000_0001_0000_4000, "pc");
    chk(link_flag, 0, "link clr");
    rd(8'h20, 32'h0000_0000);
    $display("t_exc_ret done");
  endtask
  task automatic t_barrier();
    op(cop_ops_pkg::barrier_word);
    chk({op_done, gpr_we, pc_load, cop_unusable_exc}, 8, "nop");
    chk(op_ready, 0, "hold");
    @(negedge pclk);
    chk(op_ready, 1, "free");
    $display("t_barrier done");
  endtask
  task automatic t_unusable();
    @(posedge pclk);
    cop_usable <= 1'b0;
    op(mv(cop_ops_pkg::rs_move_from, cop_ops_pkg::creg_return_pc, 5'h04));
    chk({cop_unusable_exc, gpr_we}, 2, "unusable");
    @(posedge pclk);
    cop_usable <= 1'b1;
    $display("t_unusable done");
  endtask
  task automatic t_tlb();
    logic [31:0] r;
    logic e;
    wr(8'h00, 32'h0000_1280);
    wr(8'h08, 32'h0000_1033);
    wr(8'h10, 32'h0000_0077);
    wr(8'h18, 32'h0000_0002);
    op(com(cop_ops_pkg::rs_com, cop_ops_pkg::fn_tlb_write));
    wr(8'h10, 32'h0000_0000);
    wr(8'h18, 32'h8000_0000);
    op(com(cop_ops_pkg::rs_com, cop_ops_pkg::fn_tlb_probe));
    rd(8'h18, 32'h0000_0002);
    rd(8'h08, 32'h0000_1033);
    op(com(cop_ops_pkg::rs_com, cop_ops_pkg::fn_tlb_read));
    rd(8'h10, 32'h0000_0077);
    wr(8'h08, 32'h0000_1034);
    op(com(cop_ops_pkg::rs_com, cop_ops_pkg::fn_tlb_probe));
    rd(8'h18, 32'h8000_0002);
    apb(1'b0, 8'h40, 32'h0000_0000, r, e);
    chk({e, r}, 64'h0000_0001_0000_0000, "unmapped");
    wr(8'h04, 32'h8000_0000);
    wr(8'h20, 32'h0000_0c00);
    wr(8'h10, 32'h0000_0000);
    op(com(cop_ops_pkg::rs_com, cop_ops_pkg::fn_tlb_read));
    rd(8'h10, 32'h0000_0077);
    $display("t_tlb done");
  endtask
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_tag();
    t_exc_ret();
    t_barrier();
    t_unusable();
    t_tlb();
    tally_and_finish();
  end
endmodule
